/* File: verilog/sce_port.sv */
// Serial command interpreter with array, config, control and lock access
`timescale 1ns/100ps
`include "sce_consts.svh"
module sce_port
  import sce_pkg::*;
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Serial link pins
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic        si_i,
  output logic             so_o,
  output logic             so_oe_o,
  // Array side
  output logic [8:0]       arr_rd_addr_o,
  input  wire logic [7:0]  arr_rd_data_i,
  input  wire logic        arr_busy_i,
  output logic             arr_wr_o,
  output sce_arr_wr_s      arr_wr_req_o,
  // Registers and device state
  output logic [2:0]       lock_o,
  output logic             lock_wr_o,
  output logic [15:0]      cfg_o,
  output logic [15:0]      ctrl_o,
  output logic             wel_o,
  input  wire logic [2:0]  dev_status_i,
  input  wire logic        sleep_i
);

  logic [2:0]  sck_r, sck_nxt;
  logic [2:0]  cs_r, cs_nxt;
  logic [1:0]  si_r, si_nxt;
  sce_phase_e  ph_r, ph_nxt;
  logic [2:0]  bit_r, bit_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [7:0]  op_r, op_nxt;
  logic [7:0]  arg_r, arg_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        so_r, so_nxt;
  logic        oe_r, oe_nxt;
  logic        wel_r, wel_nxt;
  logic [8:0]  rda_r, rda_nxt;
  logic [4:0]  page_r, page_nxt;
  logic [3:0]  wptr_r, wptr_nxt;
  logic [15:0] mask_r, mask_nxt;
  logic [7:0]  buf_r [16];
  logic [7:0]  buf_nxt [16];
  logic        awr_r, awr_nxt;
  sce_arr_wr_s req_r, req_nxt;
  logic [2:0]  lock_r, lock_nxt;
  logic        lwr_r, lwr_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] ctrl_r, ctrl_nxt;
  logic        rise, fall, cs_up, sel;
  logic [7:0]  b;

  // Page buffer laid flat, slot i in bits 8i+7:8i of the request
  logic [127:0] buf_flat;
  for (genvar g = 0; g < 16; g++) begin : g_flat
    assign buf_flat[g*8 +: 8] = buf_r[g];
  end

  // Page lock lookup on the 16-byte page number
  function automatic logic page_locked(input logic [2:0] lk,
                                       input logic [4:0] pg);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = `SCE_LK1_LO;
    hi = `SCE_LK1_HI;
    case (lk)
      3'h1: begin lo = `SCE_LK1_LO; hi = `SCE_LK1_HI; end
      3'h2: begin lo = `SCE_LK2_LO; hi = `SCE_LK2_HI; end
      3'h3: begin lo = `SCE_LK3_LO; hi = `SCE_LK3_HI; end
      3'h4: begin lo = `SCE_LK4_LO; hi = `SCE_LK4_HI; end
      3'h5: begin lo = `SCE_LK5_LO; hi = `SCE_LK5_HI; end
      3'h6: begin lo = `SCE_LK6_LO; hi = `SCE_LK6_HI; end
      3'h7: begin lo = `SCE_LK7_LO; hi = `SCE_LK7_HI; end
      // Code zero leaves every page writable
      default: return 1'b0;
    endcase
    return (pg >= lo) && (pg <= hi);
  endfunction : page_locked

  // Edges come from the second and third stages only
  assign rise  = sck_r[1] & ~sck_r[2];
  assign fall  = ~sck_r[1] & sck_r[2];
  assign cs_up = cs_r[1] & ~cs_r[2];
  assign sel   = ~cs_r[1];
  assign b     = {rx_r[6:0], si_r[1]};

  // Synchronisers form their own group; a low enable freezes all stages
  // together, so no half-shifted edge appears when it returns
  always_comb begin
    sck_nxt = {sck_r[1:0], sck_i};
    cs_nxt  = {cs_r[1:0], cs_n_i};
    si_nxt  = {si_r[0], si_i};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Idle levels, so no false edge follows reset
      sck_r <= 3'h0;
      cs_r  <= 3'h7;
      si_r  <= 2'h0;
    end else if (ce_i) begin
      sck_r <= sck_nxt;
      cs_r  <= cs_nxt;
      si_r  <= si_nxt;
    end
  end

  always_comb begin
    ph_nxt   = ph_r;
    bit_nxt  = bit_r;
    rx_nxt   = rx_r;
    op_nxt   = op_r;
    arg_nxt  = arg_r;
    tx_nxt   = tx_r;
    so_nxt   = so_r;
    oe_nxt   = sel;
    wel_nxt  = wel_r;
    rda_nxt  = rda_r;
    page_nxt = page_r;
    wptr_nxt = wptr_r;
    mask_nxt = mask_r;
    buf_nxt  = buf_r;
    awr_nxt  = 1'b0;
    req_nxt  = req_r;
    lock_nxt = lock_r;
    lwr_nxt  = 1'b0;
    cfg_nxt  = cfg_r;
    ctrl_nxt = ctrl_r;
    if (cs_up) begin
      // Deselect after exactly eight opcode bits arms the latch
      if (op_r == `SCE_OP_SET_LATCH && ph_r == SCE_PH_ARG1 &&
          bit_r == 3'h0) begin
        wel_nxt = 1'b1;
      end
      // A refused write leaves the latch set until cleared or used
      if (op_r == `SCE_OP_ARR_WR && ph_r == SCE_PH_DATA &&
          bit_r == 3'h0 && mask_r != 16'h0000 && wel_r &&
          !page_locked(lock_r, page_r)) begin
        awr_nxt      = 1'b1;
        req_nxt.page = page_r;
        req_nxt.mask = mask_r;
        // Unmarked slots may hold stale bytes; the mask says which count
        req_nxt.data = buf_flat;
        wel_nxt = 1'b0;
      end
      // The last complete byte wins, so extra bytes overwrite
      if (op_r == `SCE_OP_LOCK && bit_r == 3'h0 && wel_r &&
          (ph_r == SCE_PH_ARG2 || ph_r == SCE_PH_DATA)) begin
        lock_nxt = rx_r[2:0];
        lwr_nxt  = 1'b1;
        wel_nxt  = 1'b0;
      end
    end
    if (!sel) begin
      // Decoder returns to opcode state whenever deselected
      ph_nxt   = SCE_PH_OPCODE;
      bit_nxt  = 3'h0;
      rx_nxt   = 8'h00;
      op_nxt   = `SCE_OP_NONE;
      tx_nxt   = 8'h00;
      so_nxt   = 1'b0;
      mask_nxt = 16'h0000;
    end else begin
      // Nothing moves without an edge, so a paused clock just waits
      if (rise) begin
        rx_nxt  = b;
        bit_nxt = bit_r + 3'h1;
        if (bit_r == `SCE_BIT_LAST) begin
          case (ph_r)
            SCE_PH_OPCODE: begin
              ph_nxt = SCE_PH_ARG1;
              op_nxt = b;
              // Sleep is looked at once, when the opcode completes
              if (sleep_i && (b == `SCE_OP_ARR_WR ||
                  b == `SCE_OP_ARR_RD || b == `SCE_OP_ARR_STAT)) begin
                op_nxt = `SCE_OP_NONE;
              end
              if (b == `SCE_OP_CLR_LATCH) begin
                wel_nxt = 1'b0;
              end
            end
            SCE_PH_ARG1: begin
              ph_nxt  = SCE_PH_ARG2;
              arg_nxt = b;
            end
            SCE_PH_ARG2: begin
              ph_nxt = SCE_PH_DATA;
              case (op_r)
                `SCE_OP_ARR_RD: rda_nxt = {arg_r[0], b};
                `SCE_OP_ARR_WR: begin
                  page_nxt = {arg_r[0], b[7:4]};
                  wptr_nxt = b[3:0];
                end
                `SCE_OP_CFG_WR: begin
                  if (wel_r) begin
                    cfg_nxt = {arg_r, b};
                  end
                end
                `SCE_OP_CTRL_WR: ctrl_nxt = {arg_r, b};
                default: ;
              endcase
            end
            SCE_PH_DATA: begin
              if (op_r == `SCE_OP_ARR_WR) begin
                buf_nxt[wptr_r]  = b;
                mask_nxt[wptr_r] = 1'b1;
                wptr_nxt         = wptr_r + 4'h1;
              end
            end
            default: ph_nxt = SCE_PH_OPCODE;
          endcase
        end
      end
      if (fall) begin
        if (bit_r == 3'h0) begin
          case (op_r)
            `SCE_OP_ARR_RD: begin
              if (ph_r == SCE_PH_DATA) begin
                // Read data must settle within two clocks of the address
                tx_nxt  = arr_rd_data_i;
                rda_nxt = rda_r + 9'h001;
              end else begin
                tx_nxt = 8'h00;
              end
            end
            `SCE_OP_ARR_STAT: tx_nxt = {`SCE_PAD5, lock_r};
            `SCE_OP_DEV_STAT: tx_nxt = {`SCE_PAD5, dev_status_i};
            default:          tx_nxt = 8'h00;
          endcase
        end else begin
          tx_nxt = {tx_r[6:0], 1'b0};
        end
        // tx_r shifts on as usual; only the pin shows busy
        so_nxt = (op_r == `SCE_OP_ARR_STAT && arr_busy_i) ?
                 1'b1 : tx_nxt[7];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r   <= SCE_PH_OPCODE;
      bit_r  <= 3'h0;
      rx_r   <= 8'h00;
      op_r   <= `SCE_OP_NONE;
      arg_r  <= 8'h00;
      tx_r   <= 8'h00;
      so_r   <= 1'b0;
      oe_r   <= 1'b0;
      wel_r  <= 1'b0;
      rda_r  <= 9'h000;
      page_r <= 5'h00;
      wptr_r <= 4'h0;
      mask_r <= 16'h0000;
      awr_r  <= 1'b0;
      req_r  <= '0;
      lock_r <= `SCE_LOCK_RST;
      lwr_r  <= 1'b0;
      cfg_r  <= `SCE_CFG_RST;
      ctrl_r <= `SCE_CTRL_RST;
      for (int i = 0; i < 16; i++) begin
        buf_r[i] <= 8'h00;
      end
    end else if (ce_i) begin
      ph_r   <= ph_nxt;
      bit_r  <= bit_nxt;
      rx_r   <= rx_nxt;
      op_r   <= op_nxt;
      arg_r  <= arg_nxt;
      tx_r   <= tx_nxt;
      so_r   <= so_nxt;
      oe_r   <= oe_nxt;
      wel_r  <= wel_nxt;
      rda_r  <= rda_nxt;
      page_r <= page_nxt;
      wptr_r <= wptr_nxt;
      mask_r <= mask_nxt;
      awr_r  <= awr_nxt;
      req_r  <= req_nxt;
      lock_r <= lock_nxt;
      lwr_r  <= lwr_nxt;
      cfg_r  <= cfg_nxt;
      ctrl_r <= ctrl_nxt;
      buf_r  <= buf_nxt;
    end
  end

  assign so_o          = so_r;
  assign so_oe_o       = oe_r;
  assign arr_rd_addr_o = rda_r;
  assign arr_wr_o      = awr_r;
  assign arr_wr_req_o  = req_r;
  assign lock_o        = lock_r;
  assign lock_wr_o     = lwr_r;
  assign cfg_o         = cfg_r;
  assign ctrl_o        = ctrl_r;
  assign wel_o         = wel_r;

endmodule : sce_port

/* File: verilog/sce_consts.svh */
// Constants of the serial command and EEPROM port
`ifndef SCE_CONSTS_SVH
`define SCE_CONSTS_SVH
`define SCE_OP_SET_LATCH 8'h06
`define SCE_OP_CLR_LATCH 8'h04
`define SCE_OP_ARR_WR    8'h02
`define SCE_OP_ARR_RD    8'h03
`define SCE_OP_ARR_STAT  8'h05
`define SCE_OP_CFG_WR    8'h09
`define SCE_OP_CTRL_WR   8'h0a
`define SCE_OP_DEV_STAT  8'h0b
`define SCE_OP_LOCK      8'h01
`define SCE_OP_NONE      8'h00
`define SCE_CFG_RST      16'h0000
`define SCE_CTRL_RST     16'h0000
`define SCE_LOCK_RST     3'h0
`define SCE_PAD5         5'h00
`define SCE_BIT_LAST     3'h7
`define SCE_LK1_LO 5'h00
`define SCE_LK1_HI 5'h07
`define SCE_LK2_LO 5'h08
`define SCE_LK2_HI 5'h0f
`define SCE_LK3_LO 5'h10
`define SCE_LK3_HI 5'h17
`define SCE_LK4_LO 5'h18
`define SCE_LK4_HI 5'h1f
`define SCE_LK5_LO 5'h00
`define SCE_LK5_HI 5'h0f
`define SCE_LK6_LO 5'h00
`define SCE_LK6_HI 5'h00
`define SCE_LK7_LO 5'h1f
`define SCE_LK7_HI 5'h1f
`endif

/* File: verilog/sce_pkg.sv */
// Types shared by the serial command and EEPROM port
package sce_pkg;
  typedef enum logic [2:0] {
    SCE_PH_OPCODE,
    SCE_PH_ARG1,
    SCE_PH_ARG2,
    SCE_PH_DATA
  } sce_phase_e;

  typedef struct packed {
    logic [4:0]   page;
    logic [15:0]  mask;
    logic [127:0] data;
  } sce_arr_wr_s;
endpackage : sce_pkg

/* File: sim/sce_port_checker.sv */
// Concurrent checks on the serial command port pins
`timescale 1ns/100ps
module sce_port_checker (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Watched pins
  input wire logic        sck_i,
  input wire logic        cs_n_i,
  input wire logic        so_o,
  input wire logic        so_oe_o,
  input wire logic        arr_wr_o,
  input wire logic        lock_wr_o,
  input wire logic        wel_o,
  input wire logic [2:0]  lock_o,
  input wire logic [15:0] cfg_o,
  input wire logic [15:0] ctrl_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Six cycles cover the synchroniser and edge stage
  sequence s_desel; cs_n_i[*6]; endsequence
  sequence s_sel; (!cs_n_i)[*6]; endsequence
  sequence s_still; (!cs_n_i && $stable(sck_i))[*6]; endsequence
  property p_float; s_desel |-> !so_oe_o; endproperty
  property p_drive; s_sel |-> so_oe_o; endproperty
  property p_zero; !so_oe_o |-> !so_o; endproperty
  property p_static; s_still |-> $stable(so_o); endproperty
  property p_wel_rise; $rose(wel_o) |-> cs_n_i; endproperty
  property p_wr_wel; arr_wr_o |-> $past(wel_o) ##1 !wel_o; endproperty
  property p_lk_wel; lock_wr_o |-> $past(wel_o) ##1 !wel_o; endproperty
  property p_rst;
    $fell(rst_i) |-> !wel_o && !so_oe_o && lock_o == 3'h0 &&
      cfg_o == 16'h0000 && ctrl_o == 16'h0000;
  endproperty
  a_float: assert property (p_float)
    else $error("so_oe while idle");
  a_drive: assert property (p_drive)
    else $error("so_oe low in frame");
  a_zero: assert property (p_zero)
    else $error("so high undriven");
  a_static: assert property (p_static)
    else $error("so moved, sck still");
  a_wel_rise: assert property (p_wel_rise)
    else $error("latch set in frame");
  a_wr_wel: assert property (p_wr_wel)
    else $error("write latch rule");
  a_lk_wel: assert property (p_lk_wel)
    else $error("lock latch rule");
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
endmodule : sce_port_checker

bind sce_port sce_port_checker sce_port_checker_i (.clk_i(clk_i),
  .rst_i(rst_i), .sck_i(sck_i), .cs_n_i(cs_n_i), .so_o(so_o),
  .so_oe_o(so_oe_o), .arr_wr_o(arr_wr_o), .lock_wr_o(lock_wr_o),
  .wel_o(wel_o), .lock_o(lock_o), .cfg_o(cfg_o), .ctrl_o(ctrl_o));

/* File: sim/sce_host_model.sv */
// Mode 0 serial master standing in for the host controller
`timescale 1ns/100ps
module sce_host_model (
  // Serial pins
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      si_o,
  input wire logic  so_i
);
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  task automatic frame(input logic [47:0] tx, input int n,
                       output logic [47:0] rx);
    rx = 48'h0;
    cs_n_o = 1'b0;
    #30;
    for (int b = 0; b < n; b++) begin
      si_o = tx[47-b];
      #24 sck_o = 1'b1;
      rx[47-b] = so_i;
      #24 sck_o = 1'b0;
      // Clock parks low mid-byte now and then
      if (b % 7 == 3) #110;
    end
    #30 cs_n_o = 1'b1;
    si_o = ~si_o;
    #40;
  endtask : frame
endmodule : sce_host_model

/* File: sim/sce_port_tb.sv */
// Self-checking bench for the serial command port
`timescale 1ns/100ps
module sce_port_tb;
  import sce_pkg::*;
  logic clk_i, rst_i, sck, cs_n, si, so, so_oe, busy, wr, lk_wr, wel, sleep;
  logic [8:0] rd_addr;
  logic [7:0] rd_data, a, b, c;
  logic [2:0] lock, ds;
  logic [15:0] cfg, ctrl;
  logic [47:0] rx;
  logic [31:0] lfsr_r = 32'h1267ce81;
  sce_arr_wr_s req;
  int error_cnt, cmp_count, wr_cnt, lk_cnt;
  int nb;
  logic [8:0] ad;
  logic [23:0] dv;
  logic [3:0] sl;
  logic so_pin;
  function automatic logic [7:0] mem_val(input logic [8:0] ad);
    return ad[7:0] ^ {7'h00, ad[8]} ^ 8'h5a;
  endfunction : mem_val
  function automatic logic [15:0] exp_mask(input logic [3:0] st,
                                           input int n);
    logic [15:0] m;
    m = 16'h0000;
    for (int j = 0; j < n; j++) begin
      m[st + 4'(j)] = 1'b1;
    end
    return m;
  endfunction : exp_mask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  assign rd_data = mem_val(rd_addr);
  // Undriven output shows the inverse so stray samples are caught
  assign so_pin = so_oe ? so : ~so;
  sce_host_model sce_host_model_i (.sck_o(sck), .cs_n_o(cs_n), .si_o(si),
    .so_i(so_pin));
  sce_port sce_port_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .so_o(so), .so_oe_o(so_oe),
    .arr_rd_addr_o(rd_addr), .arr_rd_data_i(rd_data), .arr_busy_i(busy),
    .arr_wr_o(wr), .arr_wr_req_o(req), .lock_o(lock), .lock_wr_o(lk_wr),
    .cfg_o(cfg), .ctrl_o(ctrl), .wel_o(wel), .dev_status_i(ds),
    .sleep_i(sleep));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wr) wr_cnt++;
    if (lk_wr) lk_cnt++;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task cmd(input logic [47:0] v, input int n);
    sce_host_model_i.frame(v, n, rx);
    #40;
  endtask : cmd
  task rnd;
    lfsr_r = lfsr_next(lfsr_r);
    {a, b, c} = lfsr_r[23:0];
  endtask : rnd
  task test_done;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    #500000;
    error_cnt++;
    test_done;
  end
  initial begin
    {rst_i, busy, sleep, ds} = 6'h20;
    repeat (5) @(posedge clk_i);
    @(negedge clk_i) rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk({wel, lock, cfg, ctrl}, 32'h0);
    rnd;
    cmd({8'h02, 8'h00, 8'h10, a, 16'h0}, 32);
    chk(wr_cnt, 0);
    cmd({8'h06, 8'h02, 8'h00, 8'h10, a, 8'h0}, 40);
    chk(wr_cnt, 0);
    cmd(48'h06_0000000000, 8);
    chk(wel, 1);
    cmd(48'h04_0000000000, 8);
    chk(wel, 0);
    cmd(48'h06_0000000000, 8);
    cmd({8'h02, 8'h00, 8'h1e, a, b, c}, 48);
    chk({wr_cnt, wel}, {32'h1, 1'b0});
    chk({req.page, req.mask}, {5'h01, 16'hc001});
    chk({req.data[127:112], req.data[7:0]}, {b, a, c});
    cmd(48'h06_0000000000, 8);
    cmd({8'h02, 8'h00, 8'h20, a, 16'h0}, 28);
    chk(wr_cnt, 1);
    cmd(48'h06_0000000000, 8);
    cmd(48'h01_0300000000, 16);
    chk({lk_cnt, lock}, {32'h1, 3'h3});
    cmd(48'h06_0000000000, 8);
    cmd({8'h02, 8'h01, 8'h10, a, 16'h0}, 32);
    chk(wr_cnt, 1);
    cmd(48'h05_0000000000, 16);
    chk(rx[39:32], 8'h03);
    @(negedge clk_i) busy = 1'b1;
    cmd(48'h05_0000000000, 16);
    chk(rx[39:32], 8'hff);
    @(negedge clk_i) busy = 1'b0;
    cmd(48'h03_01ff000000, 40);
    chk(rx[23:8], {mem_val(9'h1ff), mem_val(9'h000)});
    rnd;
    cmd(48'h04_0000000000, 8);
    cmd({8'h09, a, b, 24'h0}, 24);
    chk(cfg, 16'h0000);
    cmd(48'h06_0000000000, 8);
    cmd({8'h09, a, b, 24'h0}, 24);
    chk(cfg, {a, b});
    cmd({8'h0a, b, c, 24'h0}, 24);
    chk(ctrl, {b, c});
    @(negedge clk_i) ds = a[2:0];
    cmd(48'h0b_0000000000, 16);
    chk(rx[39:32], {5'h00, a[2:0]});
    @(negedge clk_i) sleep = 1'b1;
    cmd(48'h03_0000000000, 32);
    chk(rx[23:16], 8'h00);
    @(negedge clk_i) sleep = 1'b0;
    cmd(48'h03_0000000000, 32);
    chk(rx[23:16], mem_val(9'h000));
    for (int k = 2; k < 8; k++) begin
      rnd;
      ad = {1'b0, lfsr_r[31:24]};
      nb = 1 + lfsr_r[31:30] % 3;
      dv = {a, b, c};
      cmd(48'h06_0000000000, 8);
      cmd({8'h02, 7'h00, ad, dv}, 24 + 8 * nb);
      chk({wr_cnt, wel, req.page}, {k, 1'b0, ad[8:4]});
      chk(req.mask, exp_mask(ad[3:0], nb));
      for (int j = 0; j < nb; j++) begin
        sl = ad[3:0] + 4'(j);
        chk(req.data[sl*8 +: 8], dv[23-8*j -: 8]);
      end
    end
    test_done;
  end
endmodule : sce_port_tb
